// file: shared/sss_pkg.sv
package sss_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SPEED_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_RAMP_STEP = 8'h08;
    localparam logic [7:0] ADDR_RATED_POWER = 8'h0c;
    localparam logic [7:0] ADDR_STANDSTILL = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
    localparam logic [7:0] ADDR_INT_MASK = 8'h1c;

    // Control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RAMP_STOP = 1;
    localparam int CTRL_QUICK_STOP = 2;
    localparam int CTRL_COAST = 3;
    localparam int CTRL_ACK = 4;
    localparam int CTRL_W = 4;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SEL_LSB = 3;
    localparam int STAT_REGEN = 6;
    localparam int STAT_CHAN = 7;
    localparam int STAT_PATH_A = 8;
    localparam int STAT_PATH_B = 9;

    // Interrupt status / mask fields
    localparam int EV_STO = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_REGEN = 2;
    localparam int EV_SLS_TRIP = 3;
    localparam int EV_RAMP_TRIP = 4;
    localparam int EV_W = 5;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [15:0] SPEED_LIMIT_RST = 16'h1000;
    localparam logic [15:0] RAMP_STEP_RST = 16'h0010;
    localparam logic [15:0] RATED_POWER_RST = 16'h8000;
    localparam logic [15:0] STANDSTILL_RST = 16'h0004;
    localparam logic [EV_W-1:0] INT_MASK_RST = 5'h00;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CHECK_TIME_US = 1000;
    localparam int CHECK_CYC = CHECK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int FB_WAIT_NS = 2000;
    localparam int FB_WAIT_CYC_I = FB_WAIT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] FB_WAIT_CYC = FB_WAIT_CYC_I[7:0];

    typedef enum logic [2:0]
    {
        ST_OFF = 3'b000,
        ST_RUN = 3'b001,
        ST_STOPPING = 3'b010,
        ST_STOP_RAMP = 3'b011,
        ST_LIM_SPEED = 3'b100,
        ST_STO = 3'b101,
        ST_FAULT = 3'b110
    } sss_state_t;

endpackage

// file: core/sss_channel.sv
`timescale 1ns/100ps
module sss_channel
    import sss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic pulse_req,
    input wire logic path_fb,
    input wire logic ramp_start,
    input wire logic ramp_on,
    input wire logic lim_on,
    input wire logic [15:0] speed,
    input wire logic [15:0] speed_limit,
    input wire logic [15:0] ramp_step,
    input wire logic [15:0] standstill_lvl,
    output logic drive_q,
    output logic fb_err_q,
    output logic lim_trip_q,
    output logic ramp_trip_q,
    output logic standstill_q
);

    logic [7:0] settle_q;
    logic [15:0] env_q;

    // Never switch on while feedback already shows conduction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drive_q <= 1'b0;
        else if (fb_err_q || !pulse_req)
            drive_q <= 1'b0;
        else if (!drive_q && !path_fb)
            drive_q <= 1'b1;
    end

    // Feedback must follow the drive within the settle window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            settle_q <= 8'h00;
        else if (drive_q == path_fb)
            settle_q <= 8'h00;
        else if (settle_q != FB_WAIT_CYC)
            settle_q <= settle_q + 8'h01;
    end

    // Sticky: only reset clears a path fault
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fb_err_q <= 1'b0;
        else if (settle_q == FB_WAIT_CYC)
            fb_err_q <= 1'b1;
    end

    // Speed envelope shrinks by one step per check tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            env_q <= 16'h0000;
        else if (ramp_start)
            env_q <= speed;
        else if (tick && ramp_on)
            env_q <= (env_q > ramp_step) ? env_q - ramp_step : 16'h0000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramp_trip_q <= 1'b0;
            lim_trip_q <= 1'b0;
            standstill_q <= 1'b0;
        end
        else
        begin
            ramp_trip_q <= ramp_on && !ramp_start && (speed > env_q);
            lim_trip_q <= lim_on && (speed > speed_limit);
            standstill_q <= speed <= standstill_lvl;
        end
    end

endmodule

// file: core/sss_supervisor.sv
`timescale 1ns/100ps
module sss_supervisor
    import sss_pkg::*;
#(
    parameter int CHECK_CYCLES = CHECK_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic safe_standstill_req_n,
    input wire logic monitored_stop_ramp_req_n,
    input wire logic limited_speed_watch_req_n,
    input wire logic path_fb_a,
    input wire logic path_fb_b,
    input wire logic [15:0] speed_actual,
    input wire logic [15:0] regen_power,
    output logic shutdown_a_n,
    output logic shutdown_b_n,
    output logic irq,
    output logic [2:0] safety_selected,
    output logic [2:0] safety_active,
    output logic fault_regen,
    output logic fault_channel
);

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == ADDR_CTRL) || (a == ADDR_SPEED_LIMIT) ||
            (a == ADDR_RAMP_STEP) || (a == ADDR_RATED_POWER) ||
            (a == ADDR_STANDSTILL) || (a == ADDR_STATUS) ||
            (a == ADDR_INT_STATUS) || (a == ADDR_INT_MASK);
    endfunction

    // Pin synchronisers: bit order sto, ramp, speed, fb_a, fb_b
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [4:0] sync3_q;
    logic [4:0] pins_q;
    logic [4:0] pins_d;

    logic [CTRL_W-1:0] ctrl_q;
    logic [15:0] speed_limit_q;
    logic [15:0] ramp_step_q;
    logic [15:0] rated_power_q;
    logic [15:0] standstill_q;
    logic [EV_W-1:0] int_stat_q;
    logic [EV_W-1:0] int_mask_q;
    logic [EV_W-1:0] lvl_prev_q;
    logic [EV_W-1:0] events;
    logic [31:0] status_word;
    logic [31:0] rd_word;

    sss_state_t state_q;
    logic run_prev_q;
    logic regen_q;
    logic cross_q;
    logic [31:0] tick_cnt_q;
    logic tick_q;

    logic sto_sel;
    logic ramp_sel;
    logic lim_sel;
    logic run_rise;
    logic apb_wr;
    logic ack_wr;
    logic overload;
    logic pulse_req;
    logic ramp_start;
    logic ramp_on;
    logic lim_on;
    logic chan_fault;

    logic drv_a;
    logic drv_b;
    logic err_a;
    logic err_b;
    logic lim_a;
    logic lim_b;
    logic ramp_a;
    logic ramp_b;
    logic still_a;
    logic still_b;

    // A change counts once the second and third stage agree
    assign pins_d = (sync2_q & sync3_q) | (pins_q & (sync2_q | sync3_q));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 5'h07;
            sync2_q <= 5'h07;
            sync3_q <= 5'h07;
            pins_q <= 5'h07;
        end
        else
        begin
            sync1_q <= {path_fb_b, path_fb_a, limited_speed_watch_req_n,
                monitored_stop_ramp_req_n, safe_standstill_req_n};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pins_q <= pins_d;
        end
    end

    assign sto_sel = !pins_q[0];
    assign ramp_sel = !pins_q[1];
    assign lim_sel = !pins_q[2];

    // Check tick for the stop ramp envelope
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end
        else if (tick_cnt_q == 32'(CHECK_CYCLES - 1))
        begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    assign apb_wr = psel && penable && pready && pwrite;
    assign ack_wr = apb_wr && (paddr == ADDR_CTRL) && pwdata[CTRL_ACK];
    assign run_rise = ctrl_q[CTRL_RUN] && !run_prev_q;
    assign overload = regen_power > rated_power_q;
    assign chan_fault = err_a || err_b || cross_q;

    assign pulse_req = (state_q == ST_RUN) || (state_q == ST_STOPPING) ||
        (state_q == ST_STOP_RAMP) || (state_q == ST_LIM_SPEED);
    assign ramp_on = state_q == ST_STOP_RAMP;
    assign lim_on = state_q == ST_LIM_SPEED;
    assign ramp_start = ramp_sel && pulse_req && !ramp_on;

    sss_channel u_chan_a (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .pulse_req(pulse_req),
        .path_fb(pins_q[3]),
        .ramp_start(ramp_start),
        .ramp_on(ramp_on),
        .lim_on(lim_on),
        .speed(speed_actual),
        .speed_limit(speed_limit_q),
        .ramp_step(ramp_step_q),
        .standstill_lvl(standstill_q),
        .drive_q(drv_a),
        .fb_err_q(err_a),
        .lim_trip_q(lim_a),
        .ramp_trip_q(ramp_a),
        .standstill_q(still_a)
    );

    sss_channel u_chan_b (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .pulse_req(pulse_req),
        .path_fb(pins_q[4]),
        .ramp_start(ramp_start),
        .ramp_on(ramp_on),
        .lim_on(lim_on),
        .speed(speed_actual),
        .speed_limit(speed_limit_q),
        .ramp_step(ramp_step_q),
        .standstill_lvl(standstill_q),
        .drive_q(drv_b),
        .fb_err_q(err_b),
        .lim_trip_q(lim_b),
        .ramp_trip_q(ramp_b),
        .standstill_q(still_b)
    );

    // Trip and standstill outputs come from identical inputs, so any disagreement there is a fault
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cross_q <= 1'b0;
        else if ((lim_a != lim_b) || (ramp_a != ramp_b) ||
            (still_a != still_b))
            cross_q <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_prev_q <= 1'b0;
        else
            run_prev_q <= ctrl_q[CTRL_RUN];
    end

    // Overload latch; a new overload wins over the acknowledge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            regen_q <= 1'b0;
        else if (overload && pulse_req)
            regen_q <= 1'b1;
        else if (ack_wr)
            regen_q <= 1'b0;
    end

    // Pin requests act without the controller; start needs a rising run bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ST_OFF;
        else if (chan_fault)
            state_q <= ST_FAULT;
        else if (state_q == ST_FAULT)
            state_q <= ST_FAULT;
        else if (sto_sel && state_q != ST_STO)
            state_q <= ST_STO;
        else if (pulse_req && (overload || ctrl_q[CTRL_COAST]))
            state_q <= ST_OFF;
        else
        begin
            case (state_q)
                ST_OFF:
                    if (run_rise && !regen_q && !ramp_sel && !lim_sel)
                        state_q <= ST_RUN;
                ST_RUN:
                    if (ramp_sel)
                        state_q <= ST_STOP_RAMP;
                    else if (lim_sel)
                        state_q <= ST_LIM_SPEED;
                    else if (ctrl_q[CTRL_RAMP_STOP] ||
                        ctrl_q[CTRL_QUICK_STOP])
                        state_q <= ST_STOPPING;
                ST_STOPPING:
                    if (ramp_sel)
                        state_q <= ST_STOP_RAMP;
                    else if (lim_sel)
                        state_q <= ST_LIM_SPEED;
                    else if (still_a && still_b)
                        state_q <= ST_OFF;
                ST_STOP_RAMP:
                    if (ramp_a || ramp_b)
                        state_q <= ST_FAULT;
                    else if (still_a && still_b)
                        state_q <= ST_STO;
                    else if (!ramp_sel)
                        state_q <= ST_RUN;
                ST_LIM_SPEED:
                    if (ramp_sel)
                        state_q <= ST_STOP_RAMP;
                    else if (lim_a || lim_b)
                        state_q <= ST_STO;
                    else if (!lim_sel)
                        state_q <= ST_RUN;
                ST_STO:
                    if (!sto_sel && run_rise && !regen_q)
                        state_q <= ST_RUN;
                default:
                    state_q <= ST_FAULT;
            endcase
        end
    end

    // APB registers; ack is a write-one pulse and is not stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            speed_limit_q <= SPEED_LIMIT_RST;
            ramp_step_q <= RAMP_STEP_RST;
            rated_power_q <= RATED_POWER_RST;
            standstill_q <= STANDSTILL_RST;
            int_mask_q <= INT_MASK_RST;
        end
        else if (apb_wr)
        begin
            case (paddr)
                ADDR_CTRL:
                    ctrl_q <= pwdata[CTRL_W-1:0];
                ADDR_SPEED_LIMIT:
                    speed_limit_q <= pwdata[15:0];
                ADDR_RAMP_STEP:
                    ramp_step_q <= pwdata[15:0];
                ADDR_RATED_POWER:
                    rated_power_q <= pwdata[15:0];
                ADDR_STANDSTILL:
                    standstill_q <= pwdata[15:0];
                ADDR_INT_MASK:
                    int_mask_q <= pwdata[EV_W-1:0];
                default:
                    ;
            endcase
        end
    end

    // Events are rising edges of the watched levels
    assign events = {ramp_a, lim_a, regen_q, state_q == ST_FAULT,
        state_q == ST_STO} & ~lvl_prev_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_prev_q <= 5'h00;
        else
            lvl_prev_q <= {ramp_a, lim_a, regen_q, state_q == ST_FAULT,
                state_q == ST_STO};
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_stat_q <= 5'h00;
        else if (apb_wr && paddr == ADDR_INT_STATUS)
            int_stat_q <= (int_stat_q & ~pwdata[EV_W-1:0]) | events;
        else
            int_stat_q <= int_stat_q | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(int_stat_q & int_mask_q);
    end

    always_comb
    begin
        status_word = 32'h00000000;
        status_word[STAT_STATE_LSB +: 3] = state_q;
        status_word[STAT_SEL_LSB +: 3] = {lim_sel, ramp_sel, sto_sel};
        status_word[STAT_REGEN] = regen_q;
        status_word[STAT_CHAN] = chan_fault;
        status_word[STAT_PATH_A] = drv_a;
        status_word[STAT_PATH_B] = drv_b;
    end

    always_comb
    begin
        case (paddr)
            ADDR_CTRL:
                rd_word = {28'h0000000, ctrl_q};
            ADDR_SPEED_LIMIT:
                rd_word = {16'h0000, speed_limit_q};
            ADDR_RAMP_STEP:
                rd_word = {16'h0000, ramp_step_q};
            ADDR_RATED_POWER:
                rd_word = {16'h0000, rated_power_q};
            ADDR_STANDSTILL:
                rd_word = {16'h0000, standstill_q};
            ADDR_STATUS:
                rd_word = status_word;
            ADDR_INT_STATUS:
                rd_word = {27'h0000000, int_stat_q};
            ADDR_INT_MASK:
                rd_word = {27'h0000000, int_mask_q};
            default:
                rd_word = 32'h00000000;
        endcase
    end

    // Answer registered in the setup cycle: one access cycle, no waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_known(paddr);
            prdata <= (psel && !penable && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    // Low level on either path removes the power feed
    assign shutdown_a_n = drv_a;
    assign shutdown_b_n = drv_b;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            safety_selected <= 3'h0;
            safety_active <= 3'h0;
            fault_regen <= 1'b0;
            fault_channel <= 1'b0;
        end
        else
        begin
            safety_selected <= {lim_sel, ramp_sel, sto_sel};
            safety_active <= {lim_on, ramp_on,
                state_q == ST_STO || state_q == ST_FAULT};
            fault_regen <= regen_q;
            fault_channel <= chan_fault;
        end
    end

endmodule

// file: test/sss_power_stage.sv
`timescale 1ns/100ps
module sss_power_stage (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic shutdown_a_n,
    input wire logic shutdown_b_n,
    input wire logic slow,
    input wire logic stuck_a,
    output logic path_fb_a,
    output logic path_fb_b
);
    logic [3:0] a_q;
    logic [3:0] b_q;

    // Switch settle time; slow mode lags four cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_q <= 4'h0;
            b_q <= 4'h0;
        end
        else
        begin
            a_q <= {a_q[2:0], shutdown_a_n};
            b_q <= {b_q[2:0], shutdown_b_n};
        end
    end

    // Welded switch reads conducting whatever is asked
    assign path_fb_a = stuck_a | (slow ? a_q[3] : a_q[0]);
    assign path_fb_b = slow ? b_q[3] : b_q[0];
endmodule

// file: test/sss_supervisor_asserts.sv
`timescale 1ns/100ps
module sss_supervisor_asserts
    import sss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic safe_standstill_req_n,
    input wire logic path_fb_a,
    input wire logic shutdown_a_n,
    input wire logic shutdown_b_n,
    input wire logic [2:0] safety_selected,
    input wire logic [2:0] safety_active,
    input wire logic fault_regen,
    input wire logic fault_channel
);
    logic [3:0] wr_age_q;
    logic [7:0] mism_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Cycles since the last control write, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wr_age_q <= 4'hf;
        else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
            wr_age_q <= 4'h0;
        else if (wr_age_q != 4'hf)
            wr_age_q <= wr_age_q + 4'h1;
    end

    // Length of a feedback disagreement on path a
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mism_q <= 8'h00;
        else if (path_fb_a == shutdown_a_n)
            mism_q <= 8'h00;
        else if (mism_q != 8'hff)
            mism_q <= mism_q + 8'h01;
    end

    property p_pready;
        psel && !penable |=> pready;
    endproperty
    a_pready: assert property (p_pready) else $error("pready missing");

    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");

    property p_sto_off;
        $rose(safety_active[0]) |-> ##[0:2] (!shutdown_a_n && !shutdown_b_n);
    endproperty
    a_sto_off: assert property (p_sto_off)
        else $error("paths on in torque off");

    property p_sto_req;
        (!safe_standstill_req_n)[*8] |-> ##[0:2] safety_selected[0];
    endproperty
    a_sto_req: assert property (p_sto_req)
        else $error("request not shown");

    property p_sto_exit;
        $fell(safety_active[0]) |-> wr_age_q < 4'd6;
    endproperty
    a_sto_exit: assert property (p_sto_exit)
        else $error("left torque off alone");

    property p_regen_off;
        fault_regen |-> ##[0:2] (!shutdown_a_n && !shutdown_b_n);
    endproperty
    a_regen_off: assert property (p_regen_off)
        else $error("regen fault, paths on");

    property p_chan_stay;
        fault_channel |=> fault_channel;
    endproperty
    a_chan_stay: assert property (p_chan_stay)
        else $error("channel fault cleared");

    property p_chan_off;
        fault_channel |-> ##[0:2] (!shutdown_a_n && !shutdown_b_n);
    endproperty
    a_chan_off: assert property (p_chan_off)
        else $error("channel fault, paths on");

    property p_fb_watch;
        mism_q == 8'd250 |-> fault_channel;
    endproperty
    a_fb_watch: assert property (p_fb_watch)
        else $error("feedback fault unseen");
endmodule

bind sss_supervisor sss_supervisor_asserts u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .safe_standstill_req_n(safe_standstill_req_n), .path_fb_a(path_fb_a),
    .shutdown_a_n(shutdown_a_n), .shutdown_b_n(shutdown_b_n),
    .safety_selected(safety_selected), .safety_active(safety_active),
    .fault_regen(fault_regen), .fault_channel(fault_channel)
);

// file: test/sss_supervisor_bench.sv
`timescale 1ns/100ps
module sss_supervisor_bench;
    import sss_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sto_n = 1'b1;
    logic ramp_n = 1'b1;
    logic lim_n = 1'b1;
    logic fb_a;
    logic fb_b;
    logic [15:0] speed = 16'h0;
    logic [15:0] regen = 16'h0;
    logic [15:0] lim;
    logic sd_a_n;
    logic sd_b_n;
    logic irq;
    logic f_regen;
    logic f_chan;
    logic slow = 1'b0;
    logic stuck = 1'b0;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int comparisons = 0;
    int seed = 32'h66711e88;

    sss_supervisor #(.CHECK_CYCLES(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .safe_standstill_req_n(sto_n),
        .monitored_stop_ramp_req_n(ramp_n), .limited_speed_watch_req_n(lim_n),
        .path_fb_a(fb_a), .path_fb_b(fb_b), .speed_actual(speed),
        .regen_power(regen), .shutdown_a_n(sd_a_n), .shutdown_b_n(sd_b_n),
        .irq(irq), .safety_selected(), .safety_active(),
        .fault_regen(f_regen), .fault_channel(f_chan)
    );

    sss_power_stage u_stage (
        .pclk(pclk), .presetn(presetn), .shutdown_a_n(sd_a_n),
        .shutdown_b_n(sd_b_n), .slow(slow), .stuck_a(stuck),
        .path_fb_a(fb_a), .path_fb_b(fb_b)
    );

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task conclude;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Waits for pready; no fixed latency is assumed
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task st(input logic [2:0] e);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("state", {29'h0, e}, {29'h0, rd[2:0]});
    endtask

    task paths(input logic e);
        chk("paths", {30'h0, e, e}, {30'h0, sd_a_n, sd_b_n});
    endtask

    // Run acts on a rising edge only, so clear it first
    task run;
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
    endtask

    task rst;
        presetn <= 1'b0;
        cyc(4);
        presetn <= 1'b1;
    endtask

    function automatic logic [31:0] rval(input logic [7:0] a);
        case (a)
            ADDR_SPEED_LIMIT: return {16'h0, SPEED_LIMIT_RST};
            ADDR_RAMP_STEP: return {16'h0, RAMP_STEP_RST};
            ADDR_RATED_POWER: return {16'h0, RATED_POWER_RST};
            ADDR_STANDSTILL: return {16'h0, STANDSTILL_RST};
            default: return 32'h0;
        endcase
    endfunction

    initial
    begin
        rst();
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reg", rval(8'(i * 4)), rd);
            chk("slverr", {31'h0, i == 8}, {31'h0, err});
        end
        lim = 16'h0100 + (16'($random(seed)) & 16'h0fff);
        apb(1'b1, ADDR_SPEED_LIMIT, {16'h0, lim});
        apb(1'b0, ADDR_SPEED_LIMIT, 32'h0);
        chk("limit", {16'h0, lim}, rd);
        run();
        cyc(8);
        st(ST_RUN);
        paths(1'b1);
        sto_n <= 1'b0;
        cyc(10);
        st(ST_STO);
        paths(1'b0);
        sto_n <= 1'b1;
        cyc(10);
        st(ST_STO);
        run();
        cyc(8);
        st(ST_RUN);
        speed <= lim - 16'h1 - (16'($random(seed)) & 16'h00ff);
        lim_n <= 1'b0;
        cyc(10);
        st(ST_LIM_SPEED);
        apb(1'b1, ADDR_CTRL, 32'h7);
        cyc(4);
        st(ST_LIM_SPEED);
        apb(1'b1, ADDR_CTRL, 32'h1);
        lim_n <= 1'b1;
        cyc(10);
        st(ST_RUN);
        lim_n <= 1'b0;
        cyc(10);
        speed <= lim + 16'h1 + (16'($random(seed)) & 16'h00ff);
        cyc(6);
        st(ST_STO);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_INT_MASK, 32'h1 << EV_SLS_TRIP);
        cyc(2);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_INT_STATUS, 32'h1 << EV_SLS_TRIP);
        cyc(2);
        chk("irq", 32'h0, {31'h0, irq});
        lim_n <= 1'b1;
        run();
        speed <= 16'h0100 + (16'($random(seed)) & 16'h007f);
        cyc(8);
        ramp_n <= 1'b0;
        repeat (220)
        begin
            @(posedge pclk);
            // Falls a whole step per cycle: a tick may follow entry at once
            speed <= (speed > RAMP_STEP_RST) ? speed - RAMP_STEP_RST : 16'h0;
        end
        st(ST_STO);
        ramp_n <= 1'b1;
        cyc(10);
        st(ST_STO);
        run();
        speed <= 16'h0200;
        cyc(8);
        ramp_n <= 1'b0;
        cyc(60);
        st(ST_FAULT);
        ramp_n <= 1'b1;
        speed <= 16'h0;
        rst();
        slow <= 1'b1;
        run();
        cyc(10);
        st(ST_RUN);
        // Regen only while pulsing; frequency limit is the host's
        regen <= RATED_POWER_RST + 16'h1 + (16'($random(seed)) & 16'h0fff);
        cyc(6);
        chk("regen", 32'h1, {31'h0, f_regen});
        paths(1'b0);
        regen <= 16'h0;
        run();
        cyc(6);
        st(ST_OFF);
        apb(1'b1, ADDR_CTRL, 32'h10);
        run();
        cyc(10);
        st(ST_RUN);
        apb(1'b1, ADDR_CTRL, 32'h9);
        cyc(2);
        st(ST_OFF);
        slow <= 1'b0;
        rst();
        stuck <= 1'b1;
        run();
        cyc(240);
        chk("chan", 32'h1, {31'h0, f_chan});
        paths(1'b0);
        stuck <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h10);
        run();
        cyc(10);
        st(ST_FAULT);
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        conclude();
    end
endmodule
